// ===== common/rgbdcs_map.svh
// Offsets-free constant map of the RGB driver control/status bank.
// Assumes inclusion by bare name from the design file.
`ifndef RGBDCS_MAP_SVH
`define RGBDCS_MAP_SVH

// ****************************************
// Reset values
// ****************************************
`define RGBDCS_CAL_EN_RST     1'b1
`define RGBDCS_INTENSITY_RST  4'hf
`define RGBDCS_FADE_TIME_RST  6'h00
`define RGBDCS_CURVE_RST      1'b0
`define RGBDCS_THERM_CTL_RST  1'b1
`define RGBDCS_DERATE_RST     4'hf
`define RGBDCS_RETRY_RST      1'b0
`define RGBDCS_SUPPLY_RST     1'b1
`define RGBDCS_COLOUR_RST     24'h00_0000

// ****************************************
// Field widths
// ****************************************
`define RGBDCS_NCH            3
`define RGBDCS_COLOUR_W       24
`define RGBDCS_FCODE_W        9

// ****************************************
// Timing
// ****************************************
`define RGBDCS_CLK_KHZ        200000
`define RGBDCS_FADE_STEP_MS   100
`define RGBDCS_FADE_CYC       (`RGBDCS_FADE_STEP_MS * `RGBDCS_CLK_KHZ)

`endif

// ===== common/rgbdcs_pkg.sv
// Types shared by the RGB driver control/status bank.
// Assumes the command decoder hands over one of these codes.
package rgbdcs_pkg;

	typedef enum logic [2:0] {
		CMD_SET_LED_CONTROL,
		CMD_SET_COLOR,
		CMD_SET_COLOR_SHORT,
		CMD_SET_INTENSITY,
		CMD_GET_FULL_STATUS,
		CMD_GET_STATUS,
		CMD_OTHER
	} rgbdcs_cmd_t;

	typedef enum logic [1:0] {
		COMMIT_NOW     = 2'h0,
		COMMIT_STORE   = 2'h1,
		COMMIT_STORED  = 2'h2,
		COMMIT_DISCARD = 2'h3
	} rgbdcs_commit_t;

endpackage

// ===== dv/rgbdcs_host.sv
// Frame handler stand-in: hands decoded commands to the bank.
// Assumes the bank takes a command at the rising edge with valid high.
`timescale 1ns/1ps

module rgbdcs_host (
	// Clock
	input  wire                        i_clk,
	// Decoded command
	output logic                       o_cmd_valid,
	output rgbdcs_pkg::rgbdcs_cmd_t    o_cmd,
	output logic                       o_cal_en,
	output logic                       o_therm_ctl,
	output logic                       o_global_on,
	output logic [2:0]                 o_ch_en,
	output logic [3:0]                 o_intensity,
	output logic [5:0]                 o_fade_time,
	output logic                       o_fade_on,
	output logic                       o_fade_curve,
	output rgbdcs_pkg::rgbdcs_commit_t o_commit,
	output logic [23:0]                o_colour
);
	logic [43:0] f_q;

	assign {o_cal_en, o_therm_ctl, o_global_on, o_ch_en, o_intensity,
		o_fade_time, o_fade_on, o_fade_curve} = f_q[43:26];
	assign o_commit = rgbdcs_pkg::rgbdcs_commit_t'(f_q[25:24]);
	assign o_colour = f_q[23:0];

	initial begin
		o_cmd_valid = 1'b0;
		o_cmd       = rgbdcs_pkg::CMD_OTHER;
		f_q         = 44'h000_0000_0000;
	end

	// One-cycle command; fields inverted afterwards so stale data never
	// looks like a fresh request
	task automatic send(input rgbdcs_pkg::rgbdcs_cmd_t c,
			input logic [43:0] f);
		@(posedge i_clk);
		o_cmd_valid <= 1'b1;
		o_cmd       <= c;
		f_q         <= f;
		@(posedge i_clk);
		o_cmd_valid <= 1'b0;
		o_cmd       <= rgbdcs_pkg::rgbdcs_cmd_t'(~c);
		f_q         <= ~f;
	endtask
endmodule // rgbdcs_host

// ===== dv/rgbdcs_regs_tb.sv
// Self-checking bench of the control and status bank.
// Assumes the host model owns the command port; the bench drives the rest.
`timescale 1ns/1ps

module rgbdcs_regs_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk, acc, cal, fon, fc, tick, thm, dim;
	logic        nrst = 1'b0, lit_p = 1'b1, scp_p = 1'b0, rst_p = 1'b0;
	logic        dim_p = 1'b0, tw_in = 1'b0, ts_in = 1'b0, retry = 1'b0;
	logic        rec, tw, ts, vbb, dfl, hfl, bfl;
	logic        h_valid, h_cal, h_thm, h_glob, h_fon, h_fc;
	logic [1:0]  warn, band, warn_p = 2'b00, band_in = 2'b00;
	logic [2:0]  h_ch, lit, led_flt = 3'b000;
	logic [3:0]  h_int, inten, der, der_in = 4'hf;
	logic [5:0]  h_ft, ft, err = 6'h00;
	logic [8:0]  fcode, fc_in = 9'h000;
	logic [23:0] h_col, rgb;
	rgbdcs_pkg::rgbdcs_cmd_t    h_cmd;
	rgbdcs_pkg::rgbdcs_commit_t h_cmt;
	int          n_fail = 0, compares = 0;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Short fade step keeps the tick check quick
	rgbdcs_regs #(.FADE_STEP_CYCLES(8)) u_dut (
		.i_clk(clk), .i_nrst(nrst), .i_otp_power_up_lit(lit_p),
		.i_otp_fault_scope(scp_p), .i_otp_cmd_restrict(rst_p),
		.i_otp_warn_sel(warn_p), .i_otp_dim_rate(dim_p),
		.i_cmd_valid(h_valid), .i_cmd(h_cmd), .i_cmd_cal_en(h_cal),
		.i_cmd_therm_ctl(h_thm), .i_cmd_global_on(h_glob),
		.i_cmd_ch_en(h_ch), .i_cmd_intensity(h_int),
		.i_cmd_fade_time(h_ft), .i_cmd_fade_on(h_fon),
		.i_cmd_fade_curve(h_fc), .i_cmd_commit(h_cmt),
		.i_cmd_colour(h_col), .i_err_checksum(err[0]),
		.i_err_stopbit(err[1]), .i_err_length(err[2]),
		.i_err_parity(err[3]), .i_err_sync(err[4]), .i_err_bit(err[5]),
		.i_thermal_warn(tw_in), .i_thermal_shut(ts_in),
		.i_retrying(retry), .i_derate_level(der_in),
		.i_temp_band(band_in), .i_led_fault(led_flt),
		.i_fault_code(fc_in), .o_cmd_accepted(acc), .o_cal_en(cal),
		.o_intensity(inten), .o_fade_time(ft), .o_fade_on(fon),
		.o_fade_curve(fc), .o_fade_tick(tick), .o_therm_ctl(thm),
		.o_ch_lit(lit), .o_colour(rgb), .o_warn_sel(warn),
		.o_dim_rate(dim), .o_recovery_active(rec),
		.o_derate_level(der), .o_overtemp_warn(tw),
		.o_overtemp_shut(ts), .o_temp_band(band),
		.o_fault_code(fcode), .o_supply_reset_seen(vbb),
		.o_data_fault(dfl), .o_header_fault(hfl), .o_bit_fault(bfl)
	);

	rgbdcs_host u_host (
		.i_clk(clk), .o_cmd_valid(h_valid), .o_cmd(h_cmd),
		.o_cal_en(h_cal), .o_therm_ctl(h_thm), .o_global_on(h_glob),
		.o_ch_en(h_ch), .o_intensity(h_int), .o_fade_time(h_ft),
		.o_fade_on(h_fon), .o_fade_curve(h_fc), .o_commit(h_cmt),
		.o_colour(h_col)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic cmd(input rgbdcs_pkg::rgbdcs_cmd_t c,
			input logic [43:0] f, input logic a);
		u_host.send(c, f);
		#1;
		chk(acc, a);
	endtask

	task automatic led(input logic [5:0] v, input logic a);
		cmd(rgbdcs_pkg::CMD_SET_LED_CONTROL, {v, 38'h0}, a);
	endtask

	task automatic colour(input logic [1:0] m, input logic [23:0] v,
			input logic c, input logic a);
		cmd(rgbdcs_pkg::CMD_SET_COLOR, {10'h080, 6'h3f, 1'b1, c, m, v}, a);
	endtask

	task automatic fault(input logic [2:0] v);
		@(posedge clk);
		led_flt <= v;
		@(posedge clk);
		led_flt <= 3'b000;
		step(2);
	endtask

	task automatic rst(input logic l, input logic s, input logic r);
		@(posedge clk);
		nrst   <= 1'b0;
		lit_p  <= l;
		scp_p  <= s;
		rst_p  <= r;
		warn_p <= 2'b10;
		dim_p  <= 1'b1;
		step(6);
		chk({cal, thm, inten, der, vbb, ft, rec, tw, dfl, fc, lit},
			24'hff_e000);
		@(posedge clk);
		nrst <= 1'b1;
		step(2);
		chk({fon, lit, warn, dim}, {l, {3{l}}, 3'b101});
		@(posedge clk);
		warn_p <= 2'b01;
		step(3);
		chk(warn, 2'b10);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_led;
		@(posedge clk);
		der_in <= 4'h3;
		led(6'b001101, 1'b1);
		chk({cal, thm}, 2'b00);
		step(1);
		chk({lit, der}, {3'b101, 4'hf});
		led(6'b111111, 1'b1);
		step(1);
		chk(der, 4'h3);
		led(6'b110111, 1'b1);
		step(1);
		chk(lit, 3'b000);
	endtask

	task automatic t_inten;
		logic [3:0] v[3] = '{4'h0, 4'h5, 4'hf};
		foreach (v[i]) begin
			cmd(rgbdcs_pkg::CMD_SET_INTENSITY, {6'h0, v[i], 34'h0},
				1'b1);
			chk(inten, v[i]);
		end
	endtask

	// Store and apply one idle cycle apart, as the stored-apply check wants
	task automatic t_colour;
		int n = 0;
		colour(rgbdcs_pkg::COMMIT_NOW, 24'h11_2233, 1'b1,
			1'b1);
		chk(rgb, 24'h11_2233);
		chk({ft, fon, fc, inten}, {8'hff, 4'hf});
		colour(rgbdcs_pkg::COMMIT_STORE, 24'h44_5566, 1'b0,
			1'b1);
		chk(rgb, 24'h11_2233);
		chk(fc, 1'b0);
		colour(rgbdcs_pkg::COMMIT_STORED, 24'h77_8899, 1'b0,
			1'b1);
		chk(rgb, 24'h44_5566);
		colour(rgbdcs_pkg::COMMIT_DISCARD, 24'haa_bbcc, 1'b0,
			1'b1);
		chk(rgb, 24'h44_5566);
		repeat (32) begin
			step(1);
			n += tick;
		end
		chk(n[23:0], 24'h00_0004);
	endtask

	task automatic t_err;
		logic [2:0] e;
		for (int i = 0; i < 6; i++) begin
			e = (i < 3) ? 3'b100 : (i < 5) ? 3'b010 : 3'b001;
			@(posedge clk);
			err <= 6'(1 << i);
			@(posedge clk);
			err <= 6'h00;
			step(1);
			chk({dfl, hfl, bfl}, e);
			cmd(rgbdcs_pkg::CMD_GET_STATUS, 44'h0, 1'b1);
			chk({dfl, hfl, bfl}, e);
			cmd(rgbdcs_pkg::CMD_GET_FULL_STATUS, 44'h0, 1'b1);
			chk({dfl, hfl, bfl, vbb}, 4'h0);
		end
	endtask

	task automatic t_therm;
		@(posedge clk);
		tw_in   <= 1'b1;
		ts_in   <= 1'b1;
		retry   <= 1'b1;
		der_in  <= 4'h0;
		band_in <= 2'b11;
		fc_in   <= 9'h1a5;
		step(4);
		chk({tw, ts, rec, der, band, fcode},
			{7'h70, 2'b11, 9'h1a5});
		@(posedge clk);
		tw_in <= 1'b0;
		ts_in <= 1'b0;
		retry <= 1'b0;
		step(4);
		chk({tw, ts, rec}, 3'b110);
		cmd(rgbdcs_pkg::CMD_GET_STATUS, 44'h0, 1'b1);
		chk({tw, ts}, 2'b00);
	endtask

	task automatic t_fault;
		led(6'b111111, 1'b1);
		fault(3'b010);
		chk(lit, 3'b101);
		led(6'b111111, 1'b1);
		step(1);
		chk(lit, 3'b111);
		rst(1'b1, 1'b1, 1'b0);
		fault(3'b001);
		chk(lit, 3'b000);
	endtask

	// Short colour is nonzero so a refused full colour write would show
	task automatic t_restrict;
		rst(1'b0, 1'b0, 1'b1);
		led(6'b000111, 1'b0);
		chk(cal, 1'b1);
		cmd(rgbdcs_pkg::CMD_SET_INTENSITY, {10'h007, 34'h0},
			1'b1);
		chk(inten, 4'h7);
		cmd(rgbdcs_pkg::CMD_SET_COLOR_SHORT, 44'h65_4321,
			1'b1);
		chk(rgb, 24'h65_4321);
		colour(rgbdcs_pkg::COMMIT_NOW, 24'h12_3456, 1'b1, 1'b0);
		chk(rgb, 24'h65_4321);
		cmd(rgbdcs_pkg::CMD_GET_FULL_STATUS, 44'h0, 1'b0);
		chk(vbb, 1'b1);
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		rst(1'b1, 1'b0, 1'b0);
		t_led();
		t_inten();
		t_colour();
		t_err();
		t_therm();
		t_fault();
		t_restrict();
		finish_test();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		finish_test();
	end
endmodule // rgbdcs_regs_tb

// ===== src/rgbdcs_regs.sv
// Control and status flags of a LIN-commanded three-channel LED driver.
// Assumes a frame handler on the same clock decodes commands and errors;
// thermal comparators arrive asynchronously.
//
// Overview of operation
// - Calibration enable applies matrix, resets 1
// - Four-bit intensity, only intensity command, reset 15
// - Six-bit fade time, 0.1 s steps, reset 0
// - Power-up lit bit presets switches and enables
// - Curve bit: 0 logarithmic, 1 linear fade
// - Derating bit 0 disables thermal current reduction
// - Fault scope: failing channel or all off
// - Restriction admits only short colour, intensity
// - Derating level 0..15, resets to 15
// - Two warning select bits choose threshold
// - Channel lit needs global and own enable
// - Commit mode: apply, store, apply stored, discard
// - Recovery flag high while retrying, reset 0
// - Overtemperature warning flag set and reported
// - Overtemperature shutdown flag set and reported
// - Data fault is checksum, stop, length OR
// - Header fault is parity or sync OR
// - Bit fault on readback mismatch
// - Full status query clears LIN error flags
// - Programmed settings load only in the first cycle after each reset release
`timescale 1ns/1ps
`include "rgbdcs_map.svh"

module rgbdcs_regs #(
	parameter int FADE_STEP_CYCLES = `RGBDCS_FADE_CYC
) (
	// Clock and reset
	input  wire                           i_clk,
	input  wire                           i_nrst,
	// Programmed memory contents
	input  wire                           i_otp_power_up_lit,
	input  wire                           i_otp_fault_scope,
	input  wire                           i_otp_cmd_restrict,
	input  wire  [1:0]                    i_otp_warn_sel,
	input  wire                           i_otp_dim_rate,
	// Decoded command
	input  wire                           i_cmd_valid,
	input  rgbdcs_pkg::rgbdcs_cmd_t       i_cmd,
	input  wire                           i_cmd_cal_en,
	input  wire                           i_cmd_therm_ctl,
	input  wire                           i_cmd_global_on,
	input  wire  [`RGBDCS_NCH-1:0]        i_cmd_ch_en,
	input  wire  [3:0]                    i_cmd_intensity,
	input  wire  [5:0]                    i_cmd_fade_time,
	input  wire                           i_cmd_fade_on,
	input  wire                           i_cmd_fade_curve,
	input  rgbdcs_pkg::rgbdcs_commit_t    i_cmd_commit,
	input  wire  [`RGBDCS_COLOUR_W-1:0]   i_cmd_colour,
	// LIN error pulses
	input  wire                           i_err_checksum,
	input  wire                           i_err_stopbit,
	input  wire                           i_err_length,
	input  wire                           i_err_parity,
	input  wire                           i_err_sync,
	input  wire                           i_err_bit,
	// Device condition
	input  wire                           i_thermal_warn,
	input  wire                           i_thermal_shut,
	input  wire                           i_retrying,
	input  wire  [3:0]                    i_derate_level,
	input  wire  [1:0]                    i_temp_band,
	input  wire  [`RGBDCS_NCH-1:0]        i_led_fault,
	input  wire  [`RGBDCS_FCODE_W-1:0]    i_fault_code,
	// Control outputs
	output logic                          o_cmd_accepted,
	output logic                          o_cal_en,
	output logic [3:0]                    o_intensity,
	output logic [5:0]                    o_fade_time,
	output logic                          o_fade_on,
	output logic                          o_fade_curve,
	output logic                          o_fade_tick,
	output logic                          o_therm_ctl,
	output logic [`RGBDCS_NCH-1:0]        o_ch_lit,
	output logic [`RGBDCS_COLOUR_W-1:0]   o_colour,
	output logic [1:0]                    o_warn_sel,
	output logic                          o_dim_rate,
	// Status outputs
	output logic                          o_recovery_active,
	output logic [3:0]                    o_derate_level,
	output logic                          o_overtemp_warn,
	output logic                          o_overtemp_shut,
	output logic [1:0]                    o_temp_band,
	output logic [`RGBDCS_FCODE_W-1:0]    o_fault_code,
	output logic                          o_supply_reset_seen,
	output logic                          o_data_fault,
	output logic                          o_header_fault,
	output logic                          o_bit_fault
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic allowed(input logic restr,
		input rgbdcs_pkg::rgbdcs_cmd_t c);
		allowed = !restr || c == rgbdcs_pkg::CMD_SET_COLOR_SHORT
			|| c == rgbdcs_pkg::CMD_SET_INTENSITY;
	endfunction

	// Set wins over a clear in the same cycle
	function automatic logic sticky(input logic q, input logic set,
		input logic clr);
		sticky = set | (q & ~clr);
	endfunction

	logic                         load_q;
	logic                         restrict_q;
	logic                         scope_q;
	logic                         global_q;
	logic [`RGBDCS_NCH-1:0]       ch_en_q;
	logic [`RGBDCS_NCH-1:0]       fault_off_q;
	logic [`RGBDCS_COLOUR_W-1:0]  stage_q;
	logic [24:0]                  tick_cnt_q;
	logic [1:0]                   tw_sync_q;
	logic [1:0]                   tsd_sync_q;
	logic                         acc;
	logic                         is_full;
	logic                         is_stat;

	assign acc = i_cmd_valid && allowed(restrict_q, i_cmd);
	assign is_full = acc && i_cmd == rgbdcs_pkg::CMD_GET_FULL_STATUS;
	assign is_stat = is_full || (acc && i_cmd == rgbdcs_pkg::CMD_GET_STATUS);

	// ****************************************
	// Power-on load of programmed settings
	// ****************************************
	// Loaded once after release; a later change of memory is ignored
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			load_q     <= 1'b1;
			restrict_q <= 1'b0;
			scope_q    <= 1'b0;
			o_warn_sel <= 2'h0;
			o_dim_rate <= 1'b0;
		end else if (load_q) begin
			load_q     <= 1'b0;
			restrict_q <= i_otp_cmd_restrict;
			scope_q    <= i_otp_fault_scope;
			o_warn_sel <= i_otp_warn_sel;
			o_dim_rate <= i_otp_dim_rate;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_cmd_accepted <= 1'b0;
		end else begin
			o_cmd_accepted <= acc;
		end
	end

	// ****************************************
	// LED control command fields
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_cal_en    <= `RGBDCS_CAL_EN_RST;
			o_therm_ctl <= `RGBDCS_THERM_CTL_RST;
			global_q    <= 1'b0;
			ch_en_q     <= 3'h0;
		end else if (load_q) begin
			global_q    <= i_otp_power_up_lit;
			ch_en_q     <= {`RGBDCS_NCH{i_otp_power_up_lit}};
		end else if (acc && i_cmd == rgbdcs_pkg::CMD_SET_LED_CONTROL) begin
			o_cal_en    <= i_cmd_cal_en;
			o_therm_ctl <= i_cmd_therm_ctl;
			global_q    <= i_cmd_global_on;
			ch_en_q     <= i_cmd_ch_en;
		end else if (acc && i_cmd == rgbdcs_pkg::CMD_SET_COLOR) begin
			global_q    <= i_cmd_global_on;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_intensity <= `RGBDCS_INTENSITY_RST;
		end else if (acc && i_cmd == rgbdcs_pkg::CMD_SET_INTENSITY) begin
			o_intensity <= i_cmd_intensity;
		end
	end

	// ****************************************
	// Fade settings and step tick
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_fade_time  <= `RGBDCS_FADE_TIME_RST;
			o_fade_curve <= `RGBDCS_CURVE_RST;
			o_fade_on    <= 1'b0;
		end else if (load_q) begin
			o_fade_on    <= i_otp_power_up_lit;
		end else if (acc && i_cmd == rgbdcs_pkg::CMD_SET_COLOR) begin
			o_fade_time  <= i_cmd_fade_time;
			o_fade_curve <= i_cmd_fade_curve;
			o_fade_on    <= i_cmd_fade_on;
		end
	end

	// One pulse per 0.1 s fade step for the fade engine
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			tick_cnt_q  <= 25'h000_0000;
			o_fade_tick <= 1'b0;
		end else if (tick_cnt_q == 25'(FADE_STEP_CYCLES - 1)) begin
			tick_cnt_q  <= 25'h000_0000;
			o_fade_tick <= 1'b1;
		end else begin
			tick_cnt_q  <= tick_cnt_q + 25'h000_0001;
			o_fade_tick <= 1'b0;
		end
	end

	// ****************************************
	// Colour staging
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_colour <= `RGBDCS_COLOUR_RST;
			stage_q  <= `RGBDCS_COLOUR_RST;
		end else if (acc && i_cmd == rgbdcs_pkg::CMD_SET_COLOR_SHORT) begin
			o_colour <= i_cmd_colour;
		end else if (acc && i_cmd == rgbdcs_pkg::CMD_SET_COLOR) begin
			case (i_cmd_commit)
				rgbdcs_pkg::COMMIT_NOW: begin
					o_colour <= i_cmd_colour;
				end
				rgbdcs_pkg::COMMIT_STORE: begin
					stage_q <= i_cmd_colour;
				end
				rgbdcs_pkg::COMMIT_STORED: begin
					o_colour <= stage_q;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Channel gating and fault shutdown
	// ****************************************
	// Fault latch released only by a new LED control command
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			fault_off_q <= 3'h0;
		end else begin
			for (int i = 0; i < `RGBDCS_NCH; i++) begin
				fault_off_q[i] <= sticky(fault_off_q[i],
					scope_q ? |i_led_fault : i_led_fault[i],
					acc && i_cmd == rgbdcs_pkg::CMD_SET_LED_CONTROL);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_ch_lit <= 3'h0;
		end else begin
			o_ch_lit <= {`RGBDCS_NCH{global_q}} & ch_en_q
				& ~fault_off_q;
		end
	end

	// ****************************************
	// Thermal status
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			tw_sync_q  <= 2'h0;
			tsd_sync_q <= 2'h0;
		end else begin
			tw_sync_q  <= {tw_sync_q[0], i_thermal_warn};
			tsd_sync_q <= {tsd_sync_q[0], i_thermal_shut};
		end
	end

	// Reset value is a defined zero; held until a status query
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_overtemp_warn <= 1'b0;
			o_overtemp_shut <= 1'b0;
		end else begin
			o_overtemp_warn <= sticky(o_overtemp_warn,
				tw_sync_q[1], is_stat);
			o_overtemp_shut <= sticky(o_overtemp_shut,
				tsd_sync_q[1], is_stat);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_derate_level <= `RGBDCS_DERATE_RST;
		end else begin
			o_derate_level <= o_therm_ctl ? i_derate_level
				: `RGBDCS_DERATE_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_recovery_active <= `RGBDCS_RETRY_RST;
			o_temp_band       <= 2'h0;
			o_fault_code      <= 9'h000;
		end else begin
			o_recovery_active <= i_retrying;
			o_temp_band       <= i_temp_band;
			o_fault_code      <= i_fault_code;
		end
	end

	// ****************************************
	// LIN error flags
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_data_fault        <= 1'b0;
			o_header_fault      <= 1'b0;
			o_bit_fault         <= 1'b0;
			o_supply_reset_seen <= `RGBDCS_SUPPLY_RST;
		end else begin
			o_data_fault   <= sticky(o_data_fault, i_err_checksum
				| i_err_stopbit | i_err_length, is_full);
			o_header_fault <= sticky(o_header_fault,
				i_err_parity | i_err_sync, is_full);
			o_bit_fault    <= sticky(o_bit_fault, i_err_bit,
				is_full);
			o_supply_reset_seen <= o_supply_reset_seen & ~is_full;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_store;
		acc && i_cmd == rgbdcs_pkg::CMD_SET_COLOR
			&& i_cmd_commit == rgbdcs_pkg::COMMIT_STORE;
	endsequence

	sequence s_apply;
		acc && i_cmd == rgbdcs_pkg::CMD_SET_COLOR
			&& i_cmd_commit == rgbdcs_pkg::COMMIT_STORED;
	endsequence

	a_restrict_block: assert property (
		i_cmd_valid && restrict_q && !load_q
			&& i_cmd == rgbdcs_pkg::CMD_SET_LED_CONTROL
		|=> $stable(o_cal_en) && !o_cmd_accepted)
		else $error("restricted command was executed");

	a_intensity_write: assert property (
		acc && i_cmd == rgbdcs_pkg::CMD_SET_INTENSITY
		|=> o_intensity == $past(i_cmd_intensity))
		else $error("intensity not written");

	a_commit_hold: assert property (s_store |=> $stable(o_colour))
		else $error("stored colour applied too early");
	a_commit_apply: assert property (
		s_store ##1 !acc ##1 s_apply
		|=> o_colour == $past(i_cmd_colour, 3))
		else $error("stored colour not applied");

	a_lit_gate: assert property (!global_q |=> o_ch_lit == 3'h0)
		else $error("channel lit with global switch off");

	a_fault_scope: assert property (
		i_led_fault[0] && scope_q && !load_q |-> ##2 o_ch_lit == 3'h0)
		else $error("fault did not shut all channels");

	a_data_sticky: assert property (i_err_checksum |=> o_data_fault)
		else $error("checksum error not flagged");

	a_full_clear: assert property (
		is_full && !i_err_bit && !i_err_parity && !i_err_sync
			&& !i_err_checksum && !i_err_stopbit && !i_err_length
		|=> !o_bit_fault && !o_header_fault && !o_data_fault)
		else $error("full status did not clear errors");

	a_otp_load: assert property (
		i_nrst && load_q |=> global_q == $past(i_otp_power_up_lit)
			&& ch_en_q == {3{$past(i_otp_power_up_lit)}})
		else $error("power-up state not loaded");

	a_derate_off: assert property (
		!o_therm_ctl |=> o_derate_level == 4'hf)
		else $error("derating reported while disabled");

	a_warn_set: assert property (
		i_thermal_warn |-> ##3 o_overtemp_warn)
		else $error("thermal warning not flagged");

endmodule // rgbdcs_regs
